//--- core/ppio_defines.vh
// constants for the five-port parallel i/o block
`ifndef PPIO_DEFINES_VH
`define PPIO_DEFINES_VH
// register indexes, byte address is four times the index
`define PPIO_IDX_PA      14'h1000
`define PPIO_IDX_PA_DIR  14'h1001
`define PPIO_IDX_PB      14'h1004
`define PPIO_IDX_PC      14'h1006
`define PPIO_IDX_PC_DIR  14'h1007
`define PPIO_IDX_PD      14'h1008
`define PPIO_IDX_PD_DIR  14'h1009
`define PPIO_IDX_PE      14'h100A
`define PPIO_IDX_CC45    14'h101E
`define PPIO_IDX_PACC    14'h1026
`define PPIO_IDX_SPI     14'h1028
`define PPIO_IDX_SYSTEM_OPTIONS_TWO    14'h1038
// decoded register selects
`define PPIO_SEL_NONE    4'h0
`define PPIO_SEL_PA      4'h1
`define PPIO_SEL_PA_DIR  4'h2
`define PPIO_SEL_PB      4'h3
`define PPIO_SEL_PC      4'h4
`define PPIO_SEL_PC_DIR  4'h5
`define PPIO_SEL_PD      4'h6
`define PPIO_SEL_PD_DIR  4'h7
`define PPIO_SEL_PE      4'h8
`define PPIO_SEL_CC45    4'h9
`define PPIO_SEL_PACC    4'hA
`define PPIO_SEL_SPI     4'hB
`define PPIO_SEL_SYSTEM_OPTIONS_TWO    4'hC
// field positions
`define PPIO_SYSTEM_OPTIONS_TWO_PORT_C_OPEN_DRAIN_SELECT   6
`define PPIO_PACC_I4O5   2
`define PPIO_SPI_EN      6
`define PPIO_SPI_PORT_D_OPEN_DRAIN_SELECT    5
`define PPIO_SPI_MSTR    4
`define PPIO_MODE_EXP    1
`define PPIO_PA_SHARED   3
`define PPIO_PA_ACCUM    7
`define PPIO_PD_SS       5
`define PPIO_PD_SCK      4
`define PPIO_PD_MOSI     3
`define PPIO_PD_MISO     2
`define PPIO_PD_TXD      1
`define PPIO_PD_RXD      0
// reset values and bus answers
`define PPIO_RST_BYTE    8'h00
`define PPIO_RST_HIZ     8'hFF
`define PPIO_RST_PD      6'h00
`define PPIO_RST_PD_HIZ  6'h3F
`define PPIO_RST_WORD    16'h0000
`define PPIO_RESP_OKAY   2'h0
`define PPIO_RESP_SLVERR 2'h2
`define PPIO_PAD24       24'h000000
`define PPIO_PAD16       16'h0000
`define PPIO_PAD2        2'h0
`endif

//--- core/ppio_top.v
// parallel i/o ports a to e with axi4-lite register access
`timescale 1ns/1ns
`include "ppio_defines.vh"

module ppio_top (
  input  wire        ref_clk,
  input  wire        rst,
  input  wire [15:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [15:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [1:0]  op_mode,
  input  wire [7:0]  ext_addr_hi,
  input  wire        ext_rw,
  input  wire [7:0]  ext_data_out,
  output wire [7:0]  ext_data_in,
  input  wire [7:0]  pa_in,
  output wire [7:0]  pa_out,
  output wire [7:0]  pa_oe_n,
  input  wire [4:0]  timer_oc_en,
  input  wire [4:0]  timer_oc_val,
  input  wire [15:0] timer_count,
  output wire [3:0]  ic_level,
  output wire        pulse_accum_input,
  output wire        capture4_compare5_select,
  output wire [15:0] cc45_value,
  output wire [7:0]  pb_out,
  input  wire [7:0]  pc_in,
  output wire [7:0]  pc_out,
  output wire [7:0]  pc_oe_n,
  input  wire [5:0]  pd_in,
  output wire [5:0]  pd_out,
  output wire [5:0]  pd_oe_n,
  input  wire        uart_tx_en,
  input  wire        uart_tx_val,
  input  wire        uart_rx_en,
  input  wire        spi_sck_out,
  input  wire        spi_mosi_out,
  input  wire        spi_miso_out,
  output wire        spi_enable,
  output wire        spi_master,
  output wire        spi_fault_in_n,
  input  wire [7:0]  pe_in
);

  // register address decode, shared by read and write paths
  function [3:0] ppio_dec;
    input [15:0] addr;
    input        exp_mode;
    begin
      case (addr[15:2])
        `PPIO_IDX_PA:     ppio_dec = `PPIO_SEL_PA;
        `PPIO_IDX_PA_DIR: ppio_dec = `PPIO_SEL_PA_DIR;
        `PPIO_IDX_PB:     ppio_dec = exp_mode ? `PPIO_SEL_NONE : `PPIO_SEL_PB;
        `PPIO_IDX_PC:     ppio_dec = exp_mode ? `PPIO_SEL_NONE : `PPIO_SEL_PC;
        `PPIO_IDX_PC_DIR: ppio_dec = `PPIO_SEL_PC_DIR;
        `PPIO_IDX_PD:     ppio_dec = `PPIO_SEL_PD;
        `PPIO_IDX_PD_DIR: ppio_dec = `PPIO_SEL_PD_DIR;
        `PPIO_IDX_PE:     ppio_dec = `PPIO_SEL_PE;
        `PPIO_IDX_CC45:   ppio_dec = `PPIO_SEL_CC45;
        `PPIO_IDX_PACC:   ppio_dec = `PPIO_SEL_PACC;
        `PPIO_IDX_SPI:    ppio_dec = `PPIO_SEL_SPI;
        `PPIO_IDX_SYSTEM_OPTIONS_TWO:   ppio_dec = `PPIO_SEL_SYSTEM_OPTIONS_TWO;
        default:          ppio_dec = `PPIO_SEL_NONE;
      endcase
    end
  endfunction

  // data read: output bits show the latch, input bits the pin
  function [7:0] ppio_mix;
    input [7:0] dir;
    input [7:0] latch;
    input [7:0] pin;
    begin
      ppio_mix = (dir & latch) | (~dir & pin);
    end
  endfunction

  // bus slave state
  reg        aw_full_ff;    // write address held
  reg [15:0] awaddr_ff;     // held write address
  reg        w_full_ff;     // write data held
  reg [15:0] wdata_ff;      // low two lanes are all that matter
  reg [1:0]  wstrb_ff;      // matching byte enables
  reg        bvalid_ff;     // write answer pending
  reg [1:0]  bresp_ff;      // write answer code
  reg        rvalid_ff;     // read answer pending
  reg [31:0] rdata_ff;      // read answer data
  reg [1:0]  rresp_ff;      // read answer code

  // software registers
  reg [7:0]  pa_data_ff;    // port a latch
  reg [7:0]  pa_dir_ff;     // port a direction
  reg [7:0]  pb_data_ff;    // port b latch
  reg [7:0]  pc_data_ff;    // port c latch
  reg [7:0]  pc_dir_ff;     // port c direction
  reg [5:0]  pd_data_ff;    // port d latch, six pins only
  reg [5:0]  pd_dir_ff;     // port d direction
  reg [15:0] cc45_ff;       // shared compare/capture word
  reg        i4o5_ff;       // capture4_compare5_select
  reg        spi_en_ff;     // spi enable
  reg        spi_mstr_ff;   // spi master mode
  reg        port_d_open_drain_select_ff;       // port_d_open_drain_select
  reg        port_c_open_drain_select_ff;       // port_c_open_drain_select
  reg        init_ff;       // first edge after reset release

  // pin side flops
  reg [7:0]  pa_out_ff;     // port a pin value
  reg [7:0]  pa_oe_n_ff;    // port a enable, low drives
  reg [7:0]  pb_out_ff;     // port b pin value
  reg [7:0]  pc_out_ff;     // port c pin value
  reg [7:0]  pc_oe_n_ff;    // port c enable, low drives
  reg [5:0]  pd_out_ff;     // port d pin value
  reg [5:0]  pd_oe_n_ff;    // port d enable, low drives
  reg [7:0]  ext_data_in_ff; // bus data seen on port c
  reg [3:0]  ic_level_ff;   // capture levels to timer
  reg        accum_in_ff;   // pulse accumulator level
  reg        fault_n_ff;    // spi mode-fault level
  reg        pa3_prev_ff;   // last level of pin a3

  // next values of the pin side
  reg [7:0]  nxt_pa_out;
  reg [7:0]  nxt_pa_oe_n;
  reg [7:0]  nxt_pb_out;
  reg [7:0]  nxt_pc_out;
  reg [7:0]  nxt_pc_oe_n;
  reg [5:0]  nxt_pd_out;
  reg [5:0]  nxt_pd_oe_n;
  reg [5:0]  pd_drive;      // working drive mask for port d
  reg [7:0]  rd_byte;       // low byte of read answer
  reg [15:0] rd_word;       // full read answer below pad

  wire       exp_mode = op_mode[`PPIO_MODE_EXP];
  wire [7:0] pa_lvl;        // level actually on port a pins
  wire [5:0] pd_lvl;        // level actually on port d pins
  wire       wr_go;         // both halves of a write present
  wire       rd_go;         // read address taken
  wire [3:0] wsel;
  wire [3:0] rsel;

  // a driven pin reads back its own drive, so timer inputs see it
  assign pa_lvl = (~pa_oe_n_ff & pa_out_ff) | (pa_oe_n_ff & pa_in);
  assign pd_lvl = (~pd_oe_n_ff & pd_out_ff) | (pd_oe_n_ff & pd_in);

  // handshakes: each channel accepts one item until the answer drains
  assign s_axi_awready = ~aw_full_ff & ~bvalid_ff;
  assign s_axi_wready  = ~w_full_ff & ~bvalid_ff;
  assign s_axi_arready = ~rvalid_ff;
  assign wr_go = aw_full_ff & w_full_ff & ~bvalid_ff;
  assign rd_go = s_axi_arvalid & ~rvalid_ff;
  assign wsel  = ppio_dec(awaddr_ff, exp_mode);
  assign rsel  = ppio_dec(s_axi_araddr, exp_mode);

  // read data select
  always @* begin
    rd_byte = `PPIO_RST_BYTE;
    rd_word = `PPIO_RST_WORD;
    case (rsel)
      `PPIO_SEL_PA:     rd_byte = ppio_mix(pa_dir_ff, pa_data_ff, pa_in);
      `PPIO_SEL_PA_DIR: rd_byte = pa_dir_ff;
      `PPIO_SEL_PB:     rd_byte = pb_data_ff;
      `PPIO_SEL_PC:     rd_byte = ppio_mix(pc_dir_ff, pc_data_ff, pc_in);
      `PPIO_SEL_PC_DIR: rd_byte = pc_dir_ff;
      `PPIO_SEL_PD:     rd_byte = {`PPIO_PAD2, pd_dir_ff & pd_data_ff | ~pd_dir_ff & pd_in};
      `PPIO_SEL_PD_DIR: rd_byte = {`PPIO_PAD2, pd_dir_ff};
      `PPIO_SEL_PE:     rd_byte = pe_in;
      `PPIO_SEL_CC45:   rd_word = cc45_ff;
      `PPIO_SEL_PACC: begin
        rd_byte = `PPIO_RST_BYTE;
        rd_byte[`PPIO_PACC_I4O5] = i4o5_ff;
      end
      `PPIO_SEL_SPI: begin
        rd_byte = `PPIO_RST_BYTE;
        rd_byte[`PPIO_SPI_EN] = spi_en_ff;
        rd_byte[`PPIO_SPI_PORT_D_OPEN_DRAIN_SELECT] = port_d_open_drain_select_ff;
        rd_byte[`PPIO_SPI_MSTR] = spi_mstr_ff;
      end
      `PPIO_SEL_SYSTEM_OPTIONS_TWO: begin
        rd_byte = `PPIO_RST_BYTE;
        rd_byte[`PPIO_SYSTEM_OPTIONS_TWO_PORT_C_OPEN_DRAIN_SELECT] = port_c_open_drain_select_ff;
      end
      default:          rd_byte = `PPIO_RST_BYTE;
    endcase
    if (rsel != `PPIO_SEL_CC45) begin
      rd_word = {`PPIO_RST_BYTE, rd_byte};
    end
  end

  // bus slave channels
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      aw_full_ff <= 1'b0;
      awaddr_ff  <= `PPIO_RST_WORD;
      w_full_ff  <= 1'b0;
      wdata_ff   <= `PPIO_RST_WORD;
      wstrb_ff   <= `PPIO_PAD2;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= `PPIO_RESP_OKAY;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= {`PPIO_PAD16, `PPIO_RST_WORD};
      rresp_ff   <= `PPIO_RESP_OKAY;
    end else begin
      // address and data may arrive in either order
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_ff <= 1'b1;
        awaddr_ff  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_ff <= 1'b1;
        wdata_ff  <= s_axi_wdata[15:0];
        wstrb_ff  <= s_axi_wstrb[1:0];
      end
      if (wr_go) begin
        aw_full_ff <= 1'b0;
        w_full_ff  <= 1'b0;
        bvalid_ff  <= 1'b1;
        bresp_ff   <= (wsel == `PPIO_SEL_NONE) ? `PPIO_RESP_SLVERR : `PPIO_RESP_OKAY;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
      // unmapped reads answer zero with an error code
      if (rd_go) begin
        rvalid_ff <= 1'b1;
        rdata_ff  <= {`PPIO_PAD16, rd_word};
        rresp_ff  <= (rsel == `PPIO_SEL_NONE) ? `PPIO_RESP_SLVERR : `PPIO_RESP_OKAY;
      end else if (rvalid_ff && s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  // software registers, init capture and input capture four
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pa_data_ff  <= `PPIO_RST_BYTE;
      pa_dir_ff   <= `PPIO_RST_BYTE;
      pb_data_ff  <= `PPIO_RST_BYTE;
      pc_data_ff  <= `PPIO_RST_BYTE;
      pc_dir_ff   <= `PPIO_RST_BYTE;
      pd_data_ff  <= `PPIO_RST_PD;
      pd_dir_ff   <= `PPIO_RST_PD;
      cc45_ff     <= `PPIO_RST_WORD;
      i4o5_ff     <= 1'b0;
      spi_en_ff   <= 1'b0;
      spi_mstr_ff <= 1'b0;
      port_d_open_drain_select_ff     <= 1'b0;
      port_c_open_drain_select_ff     <= 1'b0;
      init_ff     <= 1'b1;
      pa3_prev_ff <= 1'b0;
    end else begin
      pa3_prev_ff <= pa_lvl[`PPIO_PA_SHARED];
      // input latches pick up the pins right after reset
      if (init_ff) begin
        init_ff    <= 1'b0;
        pa_data_ff <= pa_in;
        pc_data_ff <= pc_in;
        pd_data_ff <= pd_in;
      end
      // with capture four selected, any edge on pin a3, own drive included, captures the count
      if (i4o5_ff && !init_ff && (pa3_prev_ff != pa_lvl[`PPIO_PA_SHARED])) begin
        cc45_ff <= timer_count;
      end
      if (wr_go && wstrb_ff[0]) begin
        case (wsel)
          `PPIO_SEL_PA:     pa_data_ff <= wdata_ff[7:0];
          `PPIO_SEL_PA_DIR: pa_dir_ff  <= wdata_ff[7:0];
          `PPIO_SEL_PB:     pb_data_ff <= wdata_ff[7:0];
          `PPIO_SEL_PC:     pc_data_ff <= wdata_ff[7:0];
          `PPIO_SEL_PC_DIR: pc_dir_ff  <= wdata_ff[7:0];
          `PPIO_SEL_PD:     pd_data_ff <= wdata_ff[5:0];
          `PPIO_SEL_PD_DIR: pd_dir_ff  <= wdata_ff[5:0];
          `PPIO_SEL_PACC:   i4o5_ff    <= wdata_ff[`PPIO_PACC_I4O5];
          `PPIO_SEL_SPI: begin
            spi_en_ff   <= wdata_ff[`PPIO_SPI_EN];
            port_d_open_drain_select_ff     <= wdata_ff[`PPIO_SPI_PORT_D_OPEN_DRAIN_SELECT];
            spi_mstr_ff <= wdata_ff[`PPIO_SPI_MSTR];
          end
          `PPIO_SEL_SYSTEM_OPTIONS_TWO:   port_c_open_drain_select_ff    <= wdata_ff[`PPIO_SYSTEM_OPTIONS_TWO_PORT_C_OPEN_DRAIN_SELECT];
          default:          port_c_open_drain_select_ff    <= port_c_open_drain_select_ff;
        endcase
      end
      // a bus write to cc45 is dropped whenever capture four is selected
      if (wr_go && (wsel == `PPIO_SEL_CC45) && !i4o5_ff) begin
        if (wstrb_ff[0]) begin
          cc45_ff[7:0] <= wdata_ff[7:0];
        end
        if (wstrb_ff[1]) begin
          cc45_ff[15:8] <= wdata_ff[15:8];
        end
      end
    end
  end

  // pin drive for ports a, b and c
  always @* begin
    // port a: direction bit, timer compares on pins 7..3
    nxt_pa_out  = pa_data_ff;
    nxt_pa_oe_n = ~pa_dir_ff;
    if (timer_oc_en[4]) begin
      nxt_pa_out[7]  = timer_oc_val[4];
      nxt_pa_oe_n[7] = 1'b0;
    end
    if (timer_oc_en[3]) begin
      nxt_pa_out[6]  = timer_oc_val[3];
      nxt_pa_oe_n[6] = 1'b0;
    end
    if (timer_oc_en[2]) begin
      nxt_pa_out[5]  = timer_oc_val[2];
      nxt_pa_oe_n[5] = 1'b0;
    end
    if (timer_oc_en[1]) begin
      nxt_pa_out[4]  = timer_oc_val[1];
      nxt_pa_oe_n[4] = 1'b0;
    end
    // compare five owns pin a3 only while capture four is off
    if (timer_oc_en[0] && !i4o5_ff) begin
      nxt_pa_out[3]  = timer_oc_val[0];
      nxt_pa_oe_n[3] = 1'b0;
    end
    // port b: latch or high address
    nxt_pb_out = exp_mode ? ext_addr_hi : pb_data_ff;
    // port c: data bus follows ext_rw in expanded modes
    if (exp_mode) begin
      nxt_pc_out  = ext_data_out;
      nxt_pc_oe_n = ext_rw ? `PPIO_RST_HIZ : `PPIO_RST_BYTE;
    end else if (port_c_open_drain_select_ff) begin
      nxt_pc_out  = `PPIO_RST_BYTE;
      nxt_pc_oe_n = ~(pc_dir_ff & ~pc_data_ff);
    end else begin
      nxt_pc_out  = pc_data_ff;
      nxt_pc_oe_n = ~pc_dir_ff;
    end
  end

  // pin drive for port d with serial overrides
  always @* begin
    nxt_pd_out = pd_data_ff;
    pd_drive   = pd_dir_ff;
    if (uart_tx_en) begin
      nxt_pd_out[`PPIO_PD_TXD] = uart_tx_val;
      pd_drive[`PPIO_PD_TXD]   = 1'b1;
    end
    if (uart_rx_en) begin
      pd_drive[`PPIO_PD_RXD] = 1'b0;
    end
    if (spi_en_ff && spi_mstr_ff) begin
      // master: pin5 stays gpio output or fault input by its bit
      nxt_pd_out[`PPIO_PD_SCK]  = spi_sck_out;
      nxt_pd_out[`PPIO_PD_MOSI] = spi_mosi_out;
      pd_drive[`PPIO_PD_MISO]   = 1'b0;
    end else if (spi_en_ff) begin
      pd_drive[`PPIO_PD_SS]     = 1'b0;
      pd_drive[`PPIO_PD_SCK]    = 1'b0;
      pd_drive[`PPIO_PD_MOSI]   = 1'b0;
      nxt_pd_out[`PPIO_PD_MISO] = spi_miso_out;
    end
    // open drain holds in every mode; a one floats
    if (port_d_open_drain_select_ff) begin
      pd_drive   = pd_drive & ~nxt_pd_out;
      nxt_pd_out = `PPIO_RST_PD;
    end
    nxt_pd_oe_n = ~pd_drive;
  end

  // pin and timer-side flops
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pa_out_ff      <= `PPIO_RST_BYTE;
      pa_oe_n_ff     <= `PPIO_RST_HIZ;
      pb_out_ff      <= `PPIO_RST_BYTE;
      pc_out_ff      <= `PPIO_RST_BYTE;
      pc_oe_n_ff     <= `PPIO_RST_HIZ;
      pd_out_ff      <= `PPIO_RST_PD;
      pd_oe_n_ff     <= `PPIO_RST_PD_HIZ;
      ext_data_in_ff <= `PPIO_RST_BYTE;
      ic_level_ff    <= 4'h0;
      accum_in_ff    <= 1'b0;
      fault_n_ff     <= 1'b1;
    end else begin
      pa_out_ff      <= nxt_pa_out;
      pa_oe_n_ff     <= nxt_pa_oe_n;
      pb_out_ff      <= nxt_pb_out;
      pc_out_ff      <= nxt_pc_out;
      pc_oe_n_ff     <= nxt_pc_oe_n;
      pd_out_ff      <= nxt_pd_out;
      pd_oe_n_ff     <= nxt_pd_oe_n;
      ext_data_in_ff <= pc_in;
      // captures one to three on pins 2..0, four on pin 3
      ic_level_ff    <= {i4o5_ff & pa_lvl[`PPIO_PA_SHARED], pa_lvl[2:0]};
      accum_in_ff    <= pa_lvl[`PPIO_PA_ACCUM];
      // fault input only in master mode with pin5 bit clear
      fault_n_ff     <= ~(spi_en_ff & spi_mstr_ff & ~pd_dir_ff[`PPIO_PD_SS])
                        | pd_lvl[`PPIO_PD_SS];
    end
  end

  // outputs
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp  = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata  = rdata_ff;
  assign s_axi_rresp  = rresp_ff;
  assign ext_data_in  = ext_data_in_ff;
  assign pa_out       = pa_out_ff;
  assign pa_oe_n      = pa_oe_n_ff;
  assign pb_out       = pb_out_ff;
  assign pc_out       = pc_out_ff;
  assign pc_oe_n      = pc_oe_n_ff;
  assign pd_out       = pd_out_ff;
  assign pd_oe_n      = pd_oe_n_ff;
  assign ic_level     = ic_level_ff;
  assign pulse_accum_input        = accum_in_ff;
  assign capture4_compare5_select = i4o5_ff;
  assign cc45_value   = cc45_ff;
  assign spi_enable   = spi_en_ff;
  assign spi_master   = spi_mstr_ff;
  assign spi_fault_in_n = fault_n_ff;

endmodule // ppio_top

//--- tb/ppio_chk.sv
// port-level checker for the parallel i/o block
`timescale 1ns/1ns
module ppio_chk (
  input wire        ref_clk,
  input wire        rst,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [1:0]  op_mode,
  input wire [7:0]  ext_addr_hi,
  input wire        ext_rw,
  input wire [7:0]  ext_data_out,
  input wire [7:0]  ext_data_in,
  input wire [7:0]  pb_out,
  input wire [7:0]  pc_in,
  input wire [7:0]  pc_out,
  input wire [7:0]  pc_oe_n,
  input wire        spi_master,
  input wire        spi_fault_in_n,
  input wire        capture4_compare5_select,
  input wire [3:0]  ic_level
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // pins are registered, so each pin output follows its cause one edge later
  AST_PB_ADDR: assert property ($past(op_mode[1]) && !$past(rst) |->
    pb_out == $past(ext_addr_hi)) else $error("port b not on high address");
  AST_PC_BUS_DIR: assert property ($past(op_mode[1]) && !$past(rst) |->
    pc_oe_n == {8{$past(ext_rw)}}) else $error("port c bus direction wrong");
  AST_PC_BUS_OUT: assert property ($past(op_mode[1]) && !$past(ext_rw) && !$past(rst)
    |-> pc_out == $past(ext_data_out)) else $error("port c bus data wrong");
  AST_BUS_IN: assert property (!$past(rst) |-> ext_data_in == $past(pc_in))
    else $error("bus input data wrong");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write answer dropped");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read answer dropped");
  AST_AR_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  AST_B_LATE: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> ##1 s_axi_bvalid) else $error("write answer late");
  // fault input only listens in master mode
  AST_FAULT_IDLE: assert property (!spi_master && !$past(spi_master)
    && !$past(rst) |-> spi_fault_in_n) else $error("fault seen outside master");
  AST_IC4_OFF: assert property (!capture4_compare5_select
    && !$past(capture4_compare5_select) && !$past(rst) |-> ic_level[3] == 1'b0)
    else $error("capture four active while compare");
endmodule // ppio_chk
bind ppio_top ppio_chk ppio_chk_inst (.*);

//--- tb/ppio_pins.sv
// board-side pin model with pull levels
`timescale 1ns/1ns
module ppio_pins (
  input  wire [7:0] pa_out,
  input  wire [7:0] pa_oe_n,
  input  wire [7:0] pc_out,
  input  wire [7:0] pc_oe_n,
  input  wire [5:0] pd_out,
  input  wire [5:0] pd_oe_n,
  input  wire [7:0] pull_a,
  input  wire [7:0] pull_c,
  input  wire [5:0] pull_d,
  output wire [7:0] pa_in,
  output wire [7:0] pc_in,
  output wire [5:0] pd_in
);
  // a floated pin settles to the board level, never the stale drive
  assign pa_in = (pa_out & ~pa_oe_n) | (pull_a & pa_oe_n);
  assign pc_in = (pc_out & ~pc_oe_n) | (pull_c & pc_oe_n);
  assign pd_in = (pd_out & ~pd_oe_n) | (pull_d & pd_oe_n);
endmodule // ppio_pins

//--- tb/ppio_top_tb.sv
// self-checking bench for the parallel i/o block
`timescale 1ns/1ns
`include "ppio_defines.vh"
module ppio_top_tb;
  reg         ref_clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  reg         s_axi_arvalid, s_axi_rready, ext_rw, uart_tx_en, uart_tx_val;
  reg         uart_rx_en, spi_sck_out, spi_mosi_out, spi_miso_out;
  reg  [15:0] s_axi_awaddr, s_axi_araddr, timer_count;
  reg  [31:0] s_axi_wdata;
  reg  [3:0]  s_axi_wstrb;
  reg  [1:0]  op_mode;
  reg  [7:0]  ext_addr_hi, ext_data_out, pe_in, pull_a, pull_c;
  reg  [5:0]  pull_d;
  reg  [4:0]  timer_oc_en, timer_oc_val;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire        pulse_accum_input, capture4_compare5_select, spi_enable, spi_master;
  wire        spi_fault_in_n;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [7:0]  ext_data_in, pa_in, pa_out, pa_oe_n, pb_out, pc_in, pc_out, pc_oe_n;
  wire [5:0]  pd_in, pd_out, pd_oe_n;
  wire [3:0]  ic_level;
  wire [15:0] cc45_value;
  integer     n_fail, samples_checked, cyc;
  reg  [31:0] rv;
  reg  [1:0]  rr;
  ppio_top ppio_top_inst (.*);
  ppio_pins ppio_pins_inst (.*);
  // free-running clock, 20 ns
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task chk(input [31:0] g, input [31:0] e);
    begin
      samples_checked = samples_checked + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("mismatch at %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task print_verdict;
    begin
      $display("checked %0d failed %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  // hang guard, well above the whole sequence
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      print_verdict;
    end
  end
  // readys looked at on the falling edge, where they are settled
  task wr(input [13:0] a, input [31:0] d, output [1:0] r);
    reg ah, wh;
    begin
      @(posedge ref_clk);
      s_axi_awaddr <= {a, 2'b00};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      ah = 1'b0;
      wh = 1'b0;
      while (!(ah && wh)) begin
        @(negedge ref_clk);
        if (s_axi_awvalid && s_axi_awready) ah = 1'b1;
        if (s_axi_wvalid && s_axi_wready) wh = 1'b1;
        @(posedge ref_clk);
        if (ah) s_axi_awvalid <= 1'b0;
        if (wh) s_axi_wvalid <= 1'b0;
      end
      @(negedge ref_clk);
      while (s_axi_bvalid !== 1'b1) @(negedge ref_clk);
      r = s_axi_bresp;
      @(posedge ref_clk);
      s_axi_bready <= 1'b0;
      repeat (2) @(negedge ref_clk);
    end
  endtask
  task rd(input [13:0] a, output [31:0] d, output [1:0] r);
    begin
      @(posedge ref_clk);
      s_axi_araddr <= {a, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      @(negedge ref_clk);
      while (s_axi_arready !== 1'b1) @(negedge ref_clk);
      @(posedge ref_clk);
      s_axi_arvalid <= 1'b0;
      @(negedge ref_clk);
      while (s_axi_rvalid !== 1'b1) @(negedge ref_clk);
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge ref_clk);
      s_axi_rready <= 1'b0;
    end
  endtask
  // reset values, outputs, direction and open drain on c
  task t_bc;
    begin
      chk(pc_oe_n, 8'hFF);
      chk(pd_oe_n, 6'h3F);
      rd(`PPIO_IDX_PB, rv, rr); chk(rv, 32'h0);
      rd(`PPIO_IDX_PC_DIR, rv, rr); chk(rv, 32'h0);
      wr(`PPIO_IDX_PB, 32'hA5, rr); chk(pb_out, 8'hA5);
      wr(`PPIO_IDX_PC_DIR, 32'h0F, rr);
      wr(`PPIO_IDX_PC, 32'h55, rr); chk({pc_oe_n, pc_out[3:0]}, 12'hF05);
      rd(`PPIO_IDX_PC, rv, rr); chk(rv, 32'hF5);
      wr(`PPIO_IDX_SYSTEM_OPTIONS_TWO, 32'h40, rr); chk({pc_oe_n, pc_out}, 16'hF500);
      rd(`PPIO_IDX_SYSTEM_OPTIONS_TWO, rv, rr); chk(rv, 32'h40);
    end
  endtask
  // expanded mode: address and data bus, b and c unmapped
  task t_exp;
    begin
      op_mode <= 2'h2;
      ext_data_out <= 8'h3C;
      ext_addr_hi <= 8'h9E;
      repeat (3) @(negedge ref_clk);
      chk({pb_out, pc_oe_n, pc_out}, 24'h9E003C);
      @(posedge ref_clk);
      pull_c <= 8'h69;
      ext_rw <= 1'b1;
      repeat (4) @(negedge ref_clk);
      chk({pc_oe_n, ext_data_in}, 16'hFF69);
      rd(`PPIO_IDX_PB, rv, rr); chk(rr, `PPIO_RESP_SLVERR);
      wr(`PPIO_IDX_PC, 32'h00, rr); chk(rr, `PPIO_RESP_SLVERR);
      wr(`PPIO_IDX_PD_DIR, 32'h3F, rr);
      wr(`PPIO_IDX_PD, 32'hFF, rr); chk({pd_oe_n, pd_out}, 12'h03F);
      rd(`PPIO_IDX_PD, rv, rr); chk(rv, 32'h3F);
      wr(`PPIO_IDX_SPI, 32'h20, rr); chk(pd_oe_n, 6'h3F);
      wr(`PPIO_IDX_PD, 32'h2A, rr); chk({pd_oe_n, pd_out}, 12'hA80);
      @(posedge ref_clk);
      op_mode <= 2'h0;
    end
  endtask
  // serial overrides on port d
  task t_spi;
    begin
      spi_sck_out <= 1'b1;
      spi_mosi_out <= 1'b1;
      wr(`PPIO_IDX_PD, 32'h00, rr);
      wr(`PPIO_IDX_SPI, 32'h50, rr); chk({pd_oe_n[5:2], pd_out[4:3]}, 6'h07);
      @(posedge ref_clk);
      pull_d <= 6'h1F;
      wr(`PPIO_IDX_PD_DIR, 32'h1F, rr); chk(spi_fault_in_n, 1'b0);
      @(posedge ref_clk);
      spi_miso_out <= 1'b1;
      wr(`PPIO_IDX_SPI, 32'h40, rr); chk({pd_oe_n[5:2], pd_out[2]}, 5'h1D);
      @(posedge ref_clk);
      uart_tx_en <= 1'b1;
      uart_rx_en <= 1'b1;
      repeat (3) @(negedge ref_clk);
      chk({pd_oe_n[1:0], pd_out[1]}, 3'h2);
    end
  endtask
  // shared capture/compare, pulse accumulator, port e, unmapped
  task t_tmr;
    begin
      wr(`PPIO_IDX_CC45, 32'h1234, rr);
      wr(`PPIO_IDX_PACC, 32'h04, rr); chk(capture4_compare5_select, 1'b1);
      wr(`PPIO_IDX_CC45, 32'hBEEF, rr);
      rd(`PPIO_IDX_CC45, rv, rr); chk(rv, 32'h1234);
      timer_count <= 16'h5A5A;
      wr(`PPIO_IDX_PA_DIR, 32'h88, rr);
      // latch came up from the pulled pins, so both driven pins show one
      chk({pa_oe_n, pa_out, spi_enable, ic_level}, 21'h0EFFFF);
      // clearing bit 3 gives a falling edge on the driven pin
      wr(`PPIO_IDX_PA, 32'h80, rr);
      repeat (3) @(negedge ref_clk);
      chk({cc45_value, pulse_accum_input}, 17'h0B4B5);
      wr(`PPIO_IDX_PA, 32'h08, rr); chk(pulse_accum_input, 1'b0);
      @(posedge ref_clk);
      pe_in <= 8'hC3;
      wr(`PPIO_IDX_PE, 32'h00, rr); chk(rr, `PPIO_RESP_OKAY);
      rd(`PPIO_IDX_PE, rv, rr); chk(rv, 32'hC3);
      rd(14'h1002, rv, rr); chk(rr, `PPIO_RESP_SLVERR);
      chk(rv, 32'h0);
    end
  endtask
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {ext_rw, uart_tx_en, uart_tx_val, uart_rx_en} = 4'h0;
    {spi_sck_out, spi_mosi_out, spi_miso_out} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, timer_count, s_axi_wdata} = 80'h0;
    s_axi_wstrb = 4'hF;
    {op_mode, ext_addr_hi, ext_data_out, pe_in} = 26'h0;
    {pull_a, pull_c, pull_d} = 22'h3FFFFF;
    {timer_oc_en, timer_oc_val} = 10'h000;
    n_fail = 0;
    samples_checked = 0;
    cyc = 0;
    rst = 1'b1;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(negedge ref_clk);
    t_bc;
    t_exp;
    t_spi;
    t_tmr;
    print_verdict;
  end
endmodule // ppio_top_tb
